// ### hdl/tx_mode_pkg.sv
package tx_mode_pkg;

	// Register byte offsets.
	localparam logic [7:0]  OFS_MODE      = 8'h00;
	localparam logic [7:0]  OFS_LIST_BASE = 8'h04;
	localparam logic [7:0]  OFS_STATUS    = 8'h08;
	localparam logic [7:0]  OFS_MASK      = 8'h0C;
	localparam logic [7:0]  OFS_POLL      = 8'h10;

	// Operating mode register field positions.
	localparam int          POS_ENH_CAPTURE = 31;
	localparam int          POS_CAPTURE     = 17;
	localparam int          POS_THR_HI      = 15;
	localparam int          POS_THR_LO      = 14;
	localparam int          POS_RUN         = 13;

	// Event status register field positions.
	localparam int          POS_TX_DONE      = 0;
	localparam int          POS_TX_STOPPED   = 1;
	localparam int          POS_TX_UNAVAIL   = 2;
	localparam int          POS_STATE_LO     = 20;
	localparam int          POS_STATE_HI     = 22;

	// Reset values.
	localparam logic [31:0] MODE_RESET      = 32'h0000_0000;
	localparam logic [31:0] LIST_BASE_RESET = 32'h0000_0000;
	localparam logic [31:0] STATUS_RESET    = 32'hFC00_0000;
	localparam logic [2:0]  EVENT_RESET     = 3'h0;
	localparam logic [2:0]  MASK_RESET      = 3'h0;

	// Bytes between consecutive transmit descriptors.
	localparam logic [31:0] DESC_STRIDE = 32'h0000_0010;

	// Transmit FIFO start thresholds in bytes, one per select code.
	localparam int          LEVEL_W  = 11;
	localparam logic [10:0] THRESH_0 = 11'h040;
	localparam logic [10:0] THRESH_1 = 11'h080;
	localparam logic [10:0] THRESH_2 = 11'h100;
	localparam logic [10:0] THRESH_3 = 11'h200;

	// Process state codes shown in the status register.
	localparam logic [2:0]  CODE_STOPPED = 3'h0;
	localparam logic [2:0]  CODE_FETCH   = 3'h1;
	localparam logic [2:0]  CODE_WAIT    = 3'h2;
	localparam logic [2:0]  CODE_DATA    = 3'h3;
	localparam logic [2:0]  CODE_SETUP   = 3'h5;
	localparam logic [2:0]  CODE_SUSP    = 3'h6;
	localparam logic [2:0]  CODE_CLOSE   = 3'h7;

	typedef enum logic [2:0] {
		TX_STOPPED,
		TX_FETCH,
		TX_DATA,
		TX_WAIT,
		TX_SETUP,
		TX_CLOSE,
		TX_SUSP
	} tx_state_type;

endpackage

// ### hdl/tx_gate_if.sv
`timescale 1ns/1ps
interface tx_gate_if;
	logic [1:0]  thr_sel;
	logic [10:0] level;
	logic        frame_complete;
	logic        armed;
	logic        start;

	modport ctrl (
		output thr_sel,
		output level,
		output frame_complete,
		output armed,
		input  start
	);

	modport gate (
		input  thr_sel,
		input  level,
		input  frame_complete,
		input  armed,
		output start
	);
endinterface

// ### hdl/tx_start_gate.sv
`timescale 1ns/1ps
module tx_start_gate
	import tx_mode_pkg::*;
(
	// Clock and reset.
	input  wire logic clk_sys_in,
	input  wire logic reset_n_in,
	// Link to the controller.
	tx_gate_if.gate   gate
);

	typedef struct packed {
		logic start;
	} gate_state_type;

	gate_state_type q;
	gate_state_type d;
	logic [10:0]    thresh;

	always_comb begin
		case (gate.thr_sel)
			2'd0: begin
				thresh = THRESH_0;
			end
			2'd1: begin
				thresh = THRESH_1;
			end
			2'd2: begin
				thresh = THRESH_2;
			end
			default: begin
				thresh = THRESH_3;
			end
		endcase
	end

	always_comb begin
		d = q;
		// Short complete frames go out without reaching the threshold.
		d.start = gate.armed && ((gate.level > thresh) || gate.frame_complete);
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign gate.start = q.start;

endmodule

// ### hdl/tx_mode_ctrl.sv
// Local design decisions: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
module tx_mode_ctrl
	import tx_mode_pkg::*;
(
	// Clock and reset.
	input  wire logic        clk_sys_in,
	input  wire logic        reset_n_in,
	// AHB-Lite slave.
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hready_in,
	output logic             hreadyout_out,
	output logic             hresp_out,
	output logic [31:0]      hrdata_out,
	// Descriptor fetch and close.
	output logic             desc_req_out,
	output logic [31:0]      desc_addr_out,
	input  wire logic        desc_ack_in,
	input  wire logic        desc_fail_in,
	input  wire logic        desc_owned_in,
	input  wire logic        desc_setup_in,
	output logic             desc_close_out,
	// Transmit data path.
	input  wire logic [10:0] tx_fifo_level_in,
	input  wire logic        tx_frame_complete_in,
	output logic             tx_start_out,
	input  wire logic        tx_done_in,
	// Capture-effect controls.
	output logic             capture_resolution_en_out,
	output logic             enhanced_capture_en_out,
	// Interrupt.
	output logic             irq_out
);

	typedef struct packed {
		tx_state_type state;
		logic         enh_cap;
		logic         cap;
		logic [1:0]   thr;
		logic         run;
		logic [31:0]  base;
		logic [31:0]  ptr;
		logic [2:0]   events;
		logic [2:0]   mask;
		logic         wr_pend;
		logic         rd_pend;
		logic [7:0]   dp_addr;
		logic         ready;
		logic [31:0]  rdata;
		logic         req;
		logic         start;
		logic         close;
		logic         irq;
	} ctl_state_type;

	ctl_state_type q;
	ctl_state_type d;
	tx_gate_if     gate_link ();

	logic          addr_take;
	logic [2:0]    set_ev;
	logic [2:0]    clr_ev;
	logic          poll;

	function automatic logic [2:0] state_code(input tx_state_type s);
		case (s)
			TX_STOPPED: begin
				return CODE_STOPPED;
			end
			TX_FETCH: begin
				return CODE_FETCH;
			end
			TX_DATA: begin
				return CODE_DATA;
			end
			TX_WAIT: begin
				return CODE_WAIT;
			end
			TX_SETUP: begin
				return CODE_SETUP;
			end
			TX_CLOSE: begin
				return CODE_CLOSE;
			end
			TX_SUSP: begin
				return CODE_SUSP;
			end
			default: begin
				return CODE_STOPPED;
			end
		endcase
	endfunction

	function automatic logic [31:0] read_word(input ctl_state_type s);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (s.dp_addr)
			OFS_MODE: begin
				v[POS_ENH_CAPTURE] = s.enh_cap;
				v[POS_CAPTURE] = s.cap;
				v[POS_THR_HI:POS_THR_LO] = s.thr;
				v[POS_RUN] = s.run;
			end
			OFS_LIST_BASE: begin
				v = s.base;
			end
			OFS_STATUS: begin
				v = STATUS_RESET;
				v[POS_TX_UNAVAIL:POS_TX_DONE] = s.events;
				v[POS_STATE_HI:POS_STATE_LO] = state_code(s.state);
			end
			OFS_MASK: begin
				v[2:0] = s.mask;
			end
			default: begin
				v = 32'h0000_0000;
			end
		endcase
		return v;
	endfunction

	assign gate_link.thr_sel = q.thr;
	assign gate_link.level = tx_fifo_level_in;
	assign gate_link.frame_complete = tx_frame_complete_in;
	assign gate_link.armed = (q.state == TX_DATA);

	tx_start_gate u_start_gate (
		.clk_sys_in (clk_sys_in),
		.reset_n_in (reset_n_in),
		.gate       (gate_link)
	);

	assign addr_take = hsel_in && htrans_in[1] && hready_in;

	always_comb begin
		d = q;
		set_ev = 3'h0;
		clr_ev = 3'h0;
		poll = 1'b0;
		d.start = 1'b0;
		d.close = 1'b0;

		// Bus: writes finish with no wait, reads insert one wait state.
		d.ready = 1'b1;
		d.wr_pend = 1'b0;
		d.rd_pend = 1'b0;
		if (q.rd_pend) begin
			d.rdata = read_word(q);
		end
		if (q.wr_pend) begin
			case (q.dp_addr)
				OFS_MODE: begin
					d.enh_cap = hwdata_in[POS_ENH_CAPTURE];
					d.cap = hwdata_in[POS_CAPTURE];
					d.thr = hwdata_in[POS_THR_HI:POS_THR_LO];
					d.run = hwdata_in[POS_RUN];
				end
				OFS_LIST_BASE: begin
					d.base = hwdata_in;
					// While stopped a new base becomes the fetch position.
					if (q.state == TX_STOPPED) begin
						d.ptr = hwdata_in;
					end
				end
				OFS_STATUS: begin
					clr_ev = hwdata_in[POS_TX_UNAVAIL:POS_TX_DONE];
				end
				OFS_MASK: begin
					d.mask = hwdata_in[2:0];
				end
				OFS_POLL: begin
					poll = 1'b1;
				end
				default: begin
				end
			endcase
		end
		if (addr_take) begin
			d.dp_addr = haddr_in[7:0];
			d.wr_pend = hwrite_in;
			d.rd_pend = !hwrite_in;
			d.ready = hwrite_in;
		end

		case (q.state)
			TX_STOPPED: begin
				if (q.run) begin
					d.state = TX_FETCH;
					d.req = 1'b1;
				end
			end
			TX_FETCH: begin
				if (desc_ack_in) begin
					d.req = 1'b0;
					if (!q.run) begin
						d.state = TX_STOPPED;
						set_ev[POS_TX_STOPPED] = 1'b1;
					end else if (desc_fail_in) begin
						d.state = TX_SUSP;
					end else if (!desc_owned_in) begin
						d.state = TX_SUSP;
						set_ev[POS_TX_UNAVAIL] = 1'b1;
					end else if (desc_setup_in) begin
						d.state = TX_SETUP;
					end else begin
						d.state = TX_DATA;
					end
				end
			end
			TX_DATA: begin
				if (gate_link.start) begin
					d.state = TX_WAIT;
					d.start = 1'b1;
				end
			end
			TX_WAIT, TX_SETUP: begin
				if (tx_done_in) begin
					d.state = TX_CLOSE;
				end
			end
			TX_CLOSE: begin
				d.close = 1'b1;
				d.ptr = q.ptr + DESC_STRIDE;
				set_ev[POS_TX_DONE] = 1'b1;
				// A cleared run bit takes effect once the frame is closed.
				if (!q.run) begin
					d.state = TX_STOPPED;
					set_ev[POS_TX_STOPPED] = 1'b1;
				end else begin
					d.state = TX_FETCH;
					d.req = 1'b1;
				end
			end
			TX_SUSP: begin
				if (!q.run) begin
					d.state = TX_STOPPED;
					set_ev[POS_TX_STOPPED] = 1'b1;
				end else if (poll) begin
					d.state = TX_FETCH;
					d.req = 1'b1;
				end
			end
			default: begin
				d.state = TX_STOPPED;
			end
		endcase

		// A new event wins over a clear in the same cycle.
		d.events = (q.events & ~clr_ev) | set_ev;
		d.irq = |(d.events & d.mask);
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			q.state <= TX_STOPPED;
			q.enh_cap <= MODE_RESET[POS_ENH_CAPTURE];
			q.cap <= MODE_RESET[POS_CAPTURE];
			q.thr <= MODE_RESET[POS_THR_HI:POS_THR_LO];
			q.run <= MODE_RESET[POS_RUN];
			q.base <= LIST_BASE_RESET;
			q.ptr <= LIST_BASE_RESET;
			q.events <= EVENT_RESET;
			q.mask <= MASK_RESET;
			q.wr_pend <= 1'b0;
			q.rd_pend <= 1'b0;
			q.dp_addr <= 8'h00;
			q.ready <= 1'b1;
			q.rdata <= 32'h0000_0000;
			q.req <= 1'b0;
			q.start <= 1'b0;
			q.close <= 1'b0;
			q.irq <= 1'b0;
		end else begin
			q <= d;
		end
	end

	assign hreadyout_out = q.ready;
	assign hresp_out = 1'b0;
	assign hrdata_out = q.rdata;
	assign desc_req_out = q.req;
	assign desc_addr_out = q.ptr;
	assign desc_close_out = q.close;
	assign tx_start_out = q.start;
	assign capture_resolution_en_out = q.cap;
	assign enhanced_capture_en_out = q.enh_cap;
	assign irq_out = q.irq;

	logic unused_ok;
	assign unused_ok = &{1'b0, haddr_in[31:8], hsize_in};

endmodule

// ### test/tx_mode_props.sv
`timescale 1ns/1ps
module tx_mode_props
	import tx_mode_pkg::*;
(
	input wire logic        clk_sys_in, reset_n_in, hsel_in, hwrite_in, hready_in,
	input wire logic        hreadyout_out, desc_req_out, desc_ack_in, desc_close_out,
	input wire logic        tx_start_out, tx_frame_complete_in,
	input wire logic        capture_resolution_en_out, enhanced_capture_en_out,
	input wire logic [1:0]  htrans_in,
	input wire logic [31:0] haddr_in, hwdata_in, desc_addr_out,
	input wire logic [10:0] tx_fifo_level_in
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!reset_n_in);
	sequence s_mode_wr;
		hsel_in && htrans_in[1] && hready_in && hwrite_in && haddr_in[7:0] == OFS_MODE ##1 1'b1;
	endsequence
	sequence s_read_wait;
		!hreadyout_out ##1 hreadyout_out;
	endsequence
	property p_capture;
		s_mode_wr |=> capture_resolution_en_out == $past(hwdata_in[POS_CAPTURE]);
	endproperty
	property p_enhanced;
		s_mode_wr |=> enhanced_capture_en_out == $past(hwdata_in[POS_ENH_CAPTURE]);
	endproperty
	property p_read_wait;
		hsel_in && htrans_in[1] && hready_in && !hwrite_in |=> s_read_wait;
	endproperty
	property p_req_hold;
		desc_req_out && !desc_ack_in |=> desc_req_out;
	endproperty
	property p_req_drop;
		desc_req_out && desc_ack_in |=> !desc_req_out;
	endproperty
	property p_start_pulse;
		tx_start_out |=> !tx_start_out;
	endproperty
	property p_start_cause;
		tx_start_out |-> $past(tx_frame_complete_in, 2) || $past(tx_fifo_level_in, 2) > THRESH_0;
	endproperty
	property p_close_step;
		desc_close_out |-> desc_addr_out == $past(desc_addr_out) + DESC_STRIDE;
	endproperty
	a_capture: assert property (p_capture) else $error("capture enable wrong");
	a_enhanced: assert property (p_enhanced) else $error("enhanced enable wrong");
	a_read_wait: assert property (p_read_wait) else $error("read wait wrong");
	a_req_hold: assert property (p_req_hold) else $error("fetch request dropped");
	a_req_drop: assert property (p_req_drop) else $error("fetch request held");
	a_start_pulse: assert property (p_start_pulse) else $error("start too long");
	a_start_cause: assert property (p_start_cause) else $error("start early");
	a_close_step: assert property (p_close_step) else $error("position not advanced");
endmodule

bind tx_mode_ctrl tx_mode_props i_props (.clk_sys_in, .reset_n_in, .hsel_in, .hwrite_in,
	.hready_in, .hreadyout_out, .desc_req_out, .desc_ack_in, .desc_close_out, .tx_start_out,
	.tx_frame_complete_in, .capture_resolution_en_out, .enhanced_capture_en_out,
	.htrans_in, .haddr_in, .hwdata_in, .desc_addr_out, .tx_fifo_level_in);

// ### test/tx_host_model.sv
`timescale 1ns/1ps
module tx_host_model (
	// Clock and reset.
	input  wire logic clk_sys_in,
	input  wire logic reset_n_in,
	// Requests and setting.
	input  wire logic desc_req_in,
	input  wire logic tx_start_in,
	input  wire logic owned_in,
	// Answers.
	output logic      desc_ack_out,
	output logic      desc_fail_out,
	output logic      desc_owned_out,
	output logic      desc_setup_out,
	output logic      tx_done_out
);
	logic [1:0] wait_q;
	logic [2:0] done_q;
	// Memory answers on the fourth request cycle; qualifiers show junk outside the answer.
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wait_q <= 2'h0;
			desc_ack_out <= 1'b0;
			done_q <= 3'h0;
		end else begin
			desc_ack_out <= desc_req_in && !desc_ack_out && wait_q == 2'h2;
			wait_q <= (desc_req_in && !desc_ack_out && wait_q != 2'h2) ? wait_q + 2'h1 : 2'h0;
			done_q <= {done_q[1:0], tx_start_in};
		end
	end
	assign desc_owned_out = desc_ack_out ? owned_in : ~owned_in;
	assign desc_fail_out  = ~desc_ack_out;
	assign desc_setup_out = ~desc_ack_out;
	assign tx_done_out    = done_q[2];
endmodule

// ### test/tx_process_mode_control_bench.sv
`timescale 1ns/1ps
module tx_process_mode_control_bench;
	import tx_mode_pkg::*;
	logic        clk_sys_in, reset_n_in, hsel_in, hwrite_in, hreadyout_out, hresp_out;
	logic        desc_req_out, desc_ack_in, desc_fail_in, desc_owned_in, desc_setup_in;
	logic        desc_close_out, tx_frame_complete_in, tx_start_out, tx_done_in, irq_out;
	logic        capture_resolution_en_out, enhanced_capture_en_out, owned_cfg;
	logic [1:0]  htrans_in;
	logic [2:0]  hsize_in;
	logic [31:0] haddr_in, hwdata_in, hrdata_out, desc_addr_out, rd;
	logic [10:0] tx_fifo_level_in;
	int          bad_count, tests_run, cycles, n;

	tx_mode_ctrl i_dut (.clk_sys_in, .reset_n_in, .hsel_in, .haddr_in, .htrans_in,
		.hwrite_in, .hsize_in, .hwdata_in, .hready_in(hreadyout_out), .hreadyout_out,
		.hresp_out, .hrdata_out, .desc_req_out, .desc_addr_out, .desc_ack_in, .desc_fail_in,
		.desc_owned_in, .desc_setup_in, .desc_close_out, .tx_fifo_level_in,
		.tx_frame_complete_in, .tx_start_out, .tx_done_in, .capture_resolution_en_out,
		.enhanced_capture_en_out, .irq_out);
	tx_host_model i_host (.clk_sys_in, .reset_n_in, .desc_req_in(desc_req_out),
		.tx_start_in(tx_start_out), .owned_in(owned_cfg), .desc_ack_out(desc_ack_in),
		.desc_fail_out(desc_fail_in), .desc_owned_out(desc_owned_in),
		.desc_setup_out(desc_setup_in), .tx_done_out(tx_done_in));

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		hsel_in <= 1'b1;
		htrans_in <= 2'b10;
		hwrite_in <= wr;
		haddr_in <= {24'h00_0000, a};
		do @(posedge clk_sys_in); while (hreadyout_out !== 1'b1);
		hsel_in <= 1'b0;
		htrans_in <= 2'b00;
		hwdata_in <= d;
		do @(posedge clk_sys_in); while (hreadyout_out !== 1'b1);
		rd = hrdata_out;
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic test_regs();
		bus(0, OFS_MODE, 0);
		check("mode reset", rd, MODE_RESET);
		bus(0, OFS_STATUS, 0);
		check("status reset", rd, STATUS_RESET);
		bus(1, OFS_MODE, 32'h8002_C000);
		bus(0, OFS_MODE, 0);
		check("mode", rd, 32'h8002_C000);
		check("capture", capture_resolution_en_out, 1);
		check("enhanced", enhanced_capture_en_out, 1);
		bus(1, OFS_MODE, 0);
		bus(0, 8'h20, 0);
		check("unmapped", rd, 0);
		check("okay response", hresp_out, 0);
		check("capture off", capture_resolution_en_out, 0);
		check("enhanced off", enhanced_capture_en_out, 0);
		$display("test regs done");
	endtask

	task automatic test_run();
		bus(1, OFS_MASK, 32'h0000_0007);
		bus(1, OFS_LIST_BASE, 32'h0000_0100);
		bus(1, OFS_MODE, 32'h0000_2000);
		do @(posedge clk_sys_in); while (desc_req_out !== 1'b1);
		check("first fetch", desc_addr_out, 32'h0000_0100);
		do @(posedge clk_sys_in); while (tx_start_out !== 1'b1);
		owned_cfg <= 1'b0;
		do @(posedge clk_sys_in); while (desc_close_out !== 1'b1);
		check("next position", desc_addr_out, 32'h0000_0110);
		check("irq done", irq_out, 1);
		repeat (10) @(posedge clk_sys_in);
		bus(0, OFS_STATUS, 0);
		check("suspended", rd, 32'hFC60_0005);
		bus(1, OFS_MASK, 0);
		bus(0, OFS_STATUS, 0);
		check("irq masked", irq_out, 0);
		bus(1, OFS_MASK, 32'h0000_0007);
		bus(1, OFS_STATUS, 32'h0000_0007);
		bus(0, OFS_STATUS, 0);
		check("cleared", rd, 32'hFC60_0000);
		check("irq cleared", irq_out, 0);
		bus(1, OFS_MODE, 32'h0000_2000);
		bus(0, OFS_STATUS, 0);
		check("start ignored", rd, 32'hFC60_0000);
		// Hand the descriptor over, then demand a poll to leave suspension.
		owned_cfg <= 1'b1;
		bus(1, OFS_POLL, 0);
		do @(posedge clk_sys_in); while (desc_req_out !== 1'b1);
		check("poll position", desc_addr_out, 32'h0000_0110);
		do @(posedge clk_sys_in); while (tx_start_out !== 1'b1);
		owned_cfg <= 1'b0;
		repeat (20) @(posedge clk_sys_in);
		bus(0, OFS_STATUS, 0);
		check("suspended again", rd, 32'hFC60_0005);
		bus(1, OFS_STATUS, 32'h0000_0007);
		$display("test run done");
	endtask

	task automatic test_stop();
		bus(1, OFS_MODE, 0);
		bus(0, OFS_STATUS, 0);
		check("stopped", rd, 32'hFC00_0002);
		bus(1, OFS_STATUS, 32'h0000_0002);
		bus(1, OFS_MODE, 0);
		bus(0, OFS_STATUS, 0);
		check("stop ignored", rd, STATUS_RESET);
		$display("test stop done");
	endtask

	task automatic test_resume();
		owned_cfg <= 1'b1;
		tx_fifo_level_in <= 11'h12C;
		bus(1, OFS_MODE, 32'h0000_E000);
		do @(posedge clk_sys_in); while (desc_req_out !== 1'b1);
		check("resume position", desc_addr_out, 32'h0000_0120);
		n = 0;
		repeat (30) begin
			@(posedge clk_sys_in);
			if (tx_start_out === 1'b1) n++;
		end
		check("below threshold", n, 0);
		tx_frame_complete_in <= 1'b1;
		do @(posedge clk_sys_in); while (tx_start_out !== 1'b1);
		bus(1, OFS_MODE, 32'h0000_C000);
		repeat (20) @(posedge clk_sys_in);
		bus(0, OFS_STATUS, 0);
		check("stop after frame", rd & 32'h0070_0003, 32'h0000_0003);
		$display("test resume done");
	endtask

	initial begin
		clk_sys_in = 1'b0;
		forever #10 clk_sys_in = ~clk_sys_in;
	end

	always @(posedge clk_sys_in) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			bad_count++;
			print_verdict();
		end
	end

	initial begin
		reset_n_in = 1'b0;
		hsel_in = 1'b0;
		htrans_in = 2'b00;
		hwrite_in = 1'b0;
		hsize_in = 3'h2;
		haddr_in = 32'h0000_0000;
		hwdata_in = 32'h0000_0000;
		tx_fifo_level_in = 11'h041;
		tx_frame_complete_in = 1'b0;
		owned_cfg = 1'b1;
		repeat (16) @(posedge clk_sys_in);
		reset_n_in <= 1'b1;
		test_regs();
		test_run();
		test_stop();
		test_resume();
		print_verdict();
	end
endmodule
